// *** logic/pacer_cfg.svh ***
/*
  Offsets, field positions, reset values and timing counts of the waveform
  pacer and run-control block. Assumes a 10 MHz core clock.
*/
`ifndef PACER_CFG_SVH
`define PACER_CFG_SVH

// Register indices; the byte address is four times the index
`define CTRL_IDX       8'h10
`define MASK_IDX       8'h11
`define STAT_IDX       8'h12
`define AUX_IDX        8'h13
`define CTR0_IDX       8'h14
`define CTR1_IDX       8'h15
`define CTR2_IDX       8'h16

// Field positions
`define CTRL_START_BIT 0
`define CTRL_GATE_BIT  1
`define CTRL_HWEN_BIT  2
`define CTRL_REFEN_BIT 6
`define MASK_SIMU_BIT  7
`define AUX_G0_BIT     0
`define WORD_END_BIT   15
`define WORD_SCAN_BIT  13
`define WORD_LOOP_BIT  12

// Reset values and answers
`define CTRL_RST       8'h00
`define MASK_RST       8'h00
`define AUX_RST        8'h01
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define LAST_DAC       3'h7

// Conversion pulse: longest width, rounded down, never below one cycle
`define CLK_PERIOD_NS  100
`define LDAC_MAX_NS    100
`define LDAC_CYC       (((`LDAC_MAX_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`LDAC_MAX_NS / `CLK_PERIOD_NS))

`endif

// *** logic/pacer_pkg.sv ***
/*
  Types of the waveform pacer and run-control block.
  Assumes the constants of pacer_cfg.svh; holds no numbers of its own beyond widths.
*/
package pacer_pkg;

  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_READ, S_HOLD, S_WRITE} seq_state_type;

  // One down-counter
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] init;
    logic [2:0]  mode;
    logic        out;
    logic        run;
  } ctr_type;

  // Whole state of the block
  typedef struct packed {
    seq_state_type st;
    logic [15:0] addr;
    logic [2:0]  sel;
    logic        end_seen;
    logic        start_pend;
    logic [7:0]  ctrl;
    logic [7:0]  mask;
    logic [7:0]  aux;
    ctr_type     c0;
    ctr_type     c1;
    ctr_type     c2;
    logic        c0_prev;
    logic        c1_prev;
    logic        c2_prev;
    logic        g0_prev;
    logic        g12_prev;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        start_prev;
    logic        trig_prev;
    logic [1:0]  ldac_cnt;
    logic        load_dac_n;
    logic        scan_end_n;
    logic        running;
    logic        tick;
    logic        tick_irq;
    logic        ref_en;
    logic        mem_rd;
    logic        dac_we;
    logic [2:0]  dac_sel;
    logic [11:0] dac_data;
    logic        awrdy;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        wrdy;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_type;

endpackage : pacer_pkg

// *** logic/waveform_pacer.sv ***
/*
  Pacing counters, waveform sequencer and run-control pins, with an AXI4-Lite
  register slave. Assumes a synchronous SRAM answering one cycle after MEM_RD,
  DACs that latch on DAC_WE and convert on LOAD_DAC_N low, and asynchronous pins.
*/
// Behaviour
// - Short low conversion pulse on each update
// - Scan-end marker fetched gives low pulse
// - Running output high while sequencer runs
// - Stop pin halts; restart from address zero
// - External trigger converts unless mask bit set
// - Start pin low stops; rising edge starts
// - Pause holds running or pending start
// - Pause lets current scan finish first
// - After pause, tick converts then resumes
// - Reference output off while enable low
// - Counter zero drives tick and interrupt
// - Software gate bit pauses pacer counting
// - Presettable 16-bit down-counters, divisor load
// - Mode zero: low until terminal count
// - Mode one: retriggerable one-shot low pulse
// - Mode two: one-clock low every N
// - Mode three: square wave, step two
// - Mode four: software strobe after load
// - Mode five: gate edge triggered strobe
// - Clock pulse steps, gate edge triggers
// - Each tick fetches words to DACs
// - Control 41h starts, 44h arms
`timescale 1ns/10ps
`include "pacer_cfg.svh"

module waveform_pacer (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        STOP_N,
  input  wire logic        START_N,
  input  wire logic        PAUSE_N,
  input  wire logic        TRIG_N,
  output logic             LOAD_DAC_N,
  output logic             SCAN_END_N,
  output logic             RUNNING,
  output logic             TICK,
  output logic             TICK_IRQ,
  output logic             REF_EN,
  output logic [15:0]      MEM_ADDR,
  output logic             MEM_RD,
  input  wire logic [15:0] MEM_RDATA,
  output logic             DAC_WE,
  output logic [2:0]       DAC_SEL,
  output logic [11:0]      DAC_DATA
);

  pacer_pkg::state_type r;
  pacer_pkg::state_type n;
  logic                 stop_l;
  logic                 start_rise;
  logic                 pause;
  logic                 trig_fall;
  logic                 pacer_tick;
  logic                 do_wr;
  logic                 halt_any;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  // Byte address matches a register index
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] idx);
    reg_hit = (a[7:2] == idx[5:0]) && (a[1:0] == 2'h0);
  endfunction : reg_hit

  // Low byte write under its strobe
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  // Loading a divisor and mode; square wave starts on its high phase
  function automatic pacer_pkg::ctr_type ctr_load(input logic [18:0] v);
    pacer_pkg::ctr_type c;
    c.init = v[15:0];
    c.cnt  = v[15:0];
    c.mode = v[18:16];
    c.out  = (v[18:16] != 3'h0);
    c.run  = (v[18:16] == 3'h2) || (v[18:16] == 3'h3) || (v[18:16] == 3'h4);
    ctr_load = c;
  endfunction : ctr_load

  // One clock of a counter; clk_en is a count step, trig a gate rising edge
  function automatic pacer_pkg::ctr_type ctr_step(input pacer_pkg::ctr_type c,
                                                  input logic clk_en, input logic gate,
                                                  input logic trig);
    pacer_pkg::ctr_type x;
    x = c;
    case (c.mode)
      3'h0:
      begin
        if (trig)
          x.run = 1'b1;
        if (c.run && gate && clk_en && !c.out)
        begin
          x.cnt = c.cnt - 16'h0001;
          x.out = (c.cnt == 16'h0001);
        end
      end
      3'h1:
      begin
        if (trig)
        begin
          x.cnt = c.init;
          x.out = 1'b0;
          x.run = 1'b1;
        end
        else if (c.run && clk_en)
        begin
          x.cnt = c.cnt - 16'h0001;
          x.out = (c.cnt == 16'h0001);
          x.run = (c.cnt != 16'h0001);
        end
      end
      3'h2:
      begin
        if (!gate)
        begin
          x.run = 1'b0;
          x.out = 1'b1;
        end
        else if (trig)
        begin
          x.cnt = c.init;
          x.run = 1'b1;
          x.out = 1'b1;
        end
        else if (c.run && clk_en)
        begin
          // Low for the step from two to one, reload at one
          x.cnt = (c.cnt == 16'h0001) ? c.init : c.cnt - 16'h0001;
          x.out = (c.cnt != 16'h0002);
        end
      end
      3'h3:
      begin
        if (!gate)
        begin
          x.run = 1'b0;
          x.out = 1'b1;
        end
        else if (trig)
        begin
          x.cnt = c.init;
          x.run = 1'b1;
          x.out = 1'b1;
        end
        else if (c.run && clk_en)
        begin
          // Odd N: high phase counts N..1, low phase N-1..2, both by two
          if (c.cnt <= 16'h0002)
          begin
            x.out = !c.out;
            x.cnt = c.out ? {c.init[15:1], 1'b0} : c.init;
          end
          else
            x.cnt = c.cnt - 16'h0002;
        end
      end
      3'h4, 3'h5:
      begin
        if (!c.out && clk_en)
          x.out = 1'b1;                                   // one input period low
        if ((c.mode == 3'h5) && trig)
        begin
          x.cnt = c.init;
          x.run = 1'b1;
        end
        else if (c.run && clk_en && (gate || (c.mode == 3'h5)))
        begin
          x.cnt = c.cnt - 16'h0001;
          x.out = (c.cnt != 16'h0001);
          x.run = (c.cnt != 16'h0001);
        end
      end
      default:
        x.run = 1'b0;
    endcase
    ctr_step = x;
  endfunction : ctr_step

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------

  // Synchronised pin views; the first stage feeds only the second
  assign stop_l     = !r.s2[0];
  assign start_rise = r.s2[1] && !r.start_prev;
  assign pause      = !r.s2[2] || r.ctrl[`CTRL_GATE_BIT];
  assign trig_fall  = !r.s2[3] && !r.trig_prev;
  assign pacer_tick = r.c2.out && !r.c2_prev;
  assign do_wr      = r.aw_have && r.w_have && !r.bvalid;
  assign halt_any   = stop_l || !r.s2[1] || do_wr;

  always_comb
  begin
    n            = r;
    n.mem_rd     = 1'b0;
    n.dac_we     = 1'b0;
    n.scan_end_n = 1'b1;
    n.s1         = {TRIG_N, PAUSE_N, START_N, STOP_N};
    n.s2         = r.s1;
    n.start_prev = r.s2[1];
    n.trig_prev  = !r.s2[3];
    n.ldac_cnt   = (r.ldac_cnt != 2'h0) ? r.ldac_cnt - 2'h1 : 2'h0;

    // Counter zero free-running on the core clock, gated by a software bit
    n.g0_prev  = r.aux[`AUX_G0_BIT];
    n.g12_prev = !r.ctrl[`CTRL_GATE_BIT];
    n.c0       = ctr_step(r.c0, 1'b1, r.aux[`AUX_G0_BIT],
                          r.aux[`AUX_G0_BIT] && !r.g0_prev);
    // Pacer: counter two counts output pulses of counter one
    n.c1       = ctr_step(r.c1, 1'b1, !r.ctrl[`CTRL_GATE_BIT],
                          !r.ctrl[`CTRL_GATE_BIT] && !r.g12_prev);
    n.c2       = ctr_step(r.c2, r.c1.out && !r.c1_prev, !r.ctrl[`CTRL_GATE_BIT],
                          !r.ctrl[`CTRL_GATE_BIT] && !r.g12_prev);
    n.c1_prev  = r.c1.out;
    n.c2_prev  = r.c2.out;
    n.c0_prev  = r.c0.out;
    n.tick     = r.c0.out;
    n.tick_irq = r.c0.out && !r.c0_prev;

    // Write channels: address and data taken in either order
    if (AWVALID && r.awrdy)
    begin
      n.aw_have = 1'b1;
      n.awaddr  = AWADDR;
    end
    if (WVALID && r.wrdy)
    begin
      n.w_have = 1'b1;
      n.wdata  = WDATA;
      n.wstrb  = WSTRB;
    end
    if (BREADY && r.bvalid)
      n.bvalid = 1'b0;
    if (do_wr)
    begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RESP_OKAY;
      if (reg_hit(r.awaddr, `CTRL_IDX))
        n.ctrl = merge8(r.ctrl, r.wdata, r.wstrb);
      else if (reg_hit(r.awaddr, `MASK_IDX))
        n.mask = merge8(r.mask, r.wdata, r.wstrb);
      else if (reg_hit(r.awaddr, `AUX_IDX))
        n.aux = merge8(r.aux, r.wdata, r.wstrb);
      else if (reg_hit(r.awaddr, `CTR0_IDX) && (r.wstrb[2:0] == 3'h7))
        n.c0 = ctr_load(r.wdata[18:0]);
      else if (reg_hit(r.awaddr, `CTR1_IDX) && (r.wstrb[2:0] == 3'h7))
        n.c1 = ctr_load(r.wdata[18:0]);
      else if (reg_hit(r.awaddr, `CTR2_IDX) && (r.wstrb[2:0] == 3'h7))
        n.c2 = ctr_load(r.wdata[18:0]);
      else if (!reg_hit(r.awaddr, `STAT_IDX))
        n.bresp = `RESP_SLVERR;
    end
    n.awrdy = !n.aw_have && !n.bvalid;
    n.wrdy  = !n.w_have && !n.bvalid;

    // Read channel: one read at a time, answered the cycle after it is taken
    if (RREADY && r.rvalid)
      n.rvalid = 1'b0;
    if (ARVALID && r.arrdy)
    begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      n.rdata  = 32'h0;
      if (reg_hit(ARADDR, `CTRL_IDX))
        n.rdata[7:0] = r.ctrl;
      else if (reg_hit(ARADDR, `MASK_IDX))
        n.rdata[7:0] = r.mask;
      else if (reg_hit(ARADDR, `AUX_IDX))
        n.rdata[7:0] = r.aux;
      else if (reg_hit(ARADDR, `STAT_IDX))
        n.rdata = {r.addr, 8'h0, r.start_pend, pause, r.c2.out, r.c0.out, r.sel, r.running};
      else if (reg_hit(ARADDR, `CTR0_IDX))
        n.rdata = {12'h0, r.c0.out, r.c0.mode, r.c0.cnt};
      else if (reg_hit(ARADDR, `CTR1_IDX))
        n.rdata = {12'h0, r.c1.out, r.c1.mode, r.c1.cnt};
      else if (reg_hit(ARADDR, `CTR2_IDX))
        n.rdata = {12'h0, r.c2.out, r.c2.mode, r.c2.cnt};
      else
        n.rresp = `RESP_SLVERR;
    end
    n.arrdy = !n.rvalid;

    // External conversion trigger, unless software masks it
    if (trig_fall && !r.mask[`MASK_SIMU_BIT])
      n.ldac_cnt = 2'(`LDAC_CYC);

    // Sequencer
    case (r.st)
      pacer_pkg::S_IDLE:
      begin
        if ((do_wr && reg_hit(r.awaddr, `CTRL_IDX) && r.wstrb[0] && r.wdata[`CTRL_START_BIT])
            || (start_rise && r.ctrl[`CTRL_HWEN_BIT]))
        begin
          n.start_pend              = 1'b1;
          n.ctrl[`CTRL_START_BIT]   = 1'b1;
        end
        if ((n.start_pend || r.start_pend) && !pause)
        begin
          n.st         = pacer_pkg::S_WAIT;
          n.start_pend = 1'b0;
          n.sel        = 3'h0;
          n.end_seen   = 1'b0;
        end
      end
      pacer_pkg::S_WAIT:
      begin
        // Paused: no tick is taken; the first tick after release converts
        if (!pause && pacer_tick)
        begin
          n.ldac_cnt = 2'(`LDAC_CYC);
          n.st       = pacer_pkg::S_READ;
        end
      end
      pacer_pkg::S_READ:
      begin
        n.mem_rd = 1'b1;
        n.st     = pacer_pkg::S_HOLD;
      end
      pacer_pkg::S_HOLD:
        n.st = pacer_pkg::S_WRITE;
      pacer_pkg::S_WRITE:
      begin
        n.dac_we     = 1'b1;
        n.dac_sel    = r.sel;
        n.dac_data   = MEM_RDATA[11:0];
        n.scan_end_n = !MEM_RDATA[`WORD_SCAN_BIT];
        n.addr       = MEM_RDATA[`WORD_LOOP_BIT] ? 16'h0 : r.addr + 16'h0001;
        n.end_seen   = r.end_seen || MEM_RDATA[`WORD_END_BIT];
        // Pause is not looked at here, so pause never cuts a started scan short
        if (MEM_RDATA[`WORD_SCAN_BIT] || (r.sel == `LAST_DAC))
        begin
          n.sel = 3'h0;
          n.st  = n.end_seen ? pacer_pkg::S_IDLE : pacer_pkg::S_WAIT;
          if (n.end_seen)
            n.ctrl[`CTRL_START_BIT] = 1'b0;
        end
        else
        begin
          n.sel = r.sel + 3'h1;
          n.st  = pacer_pkg::S_READ;
        end
      end
      default:
        n.st = pacer_pkg::S_IDLE;
    endcase

    // Software clearing the start bit stops a running sequencer
    if ((r.st != pacer_pkg::S_IDLE) && !n.ctrl[`CTRL_START_BIT])
      n.st = pacer_pkg::S_IDLE;
    // Start pin low stops the generator; stop pin also rewinds the address
    if (stop_l || !r.s2[1])
    begin
      n.st                    = pacer_pkg::S_IDLE;
      n.start_pend            = 1'b0;
      n.sel                   = 3'h0;
      n.ctrl[`CTRL_START_BIT] = 1'b0;
      if (stop_l)
        n.addr = 16'h0;
    end

    n.load_dac_n = (n.ldac_cnt == 2'h0);
    n.running    = (n.st != pacer_pkg::S_IDLE);
    n.ref_en     = n.ctrl[`CTRL_REFEN_BIT];
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------

  // Reset leaves every counter idle with a high output
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      r            <= '0;
      r.st         <= pacer_pkg::S_IDLE;
      r.ctrl       <= `CTRL_RST;
      r.mask       <= `MASK_RST;
      r.aux        <= `AUX_RST;
      r.c0.out     <= 1'b1;
      r.c1.out     <= 1'b1;
      r.c2.out     <= 1'b1;
      r.c0_prev    <= 1'b1;
      r.c1_prev    <= 1'b1;
      r.c2_prev    <= 1'b1;
      r.s1         <= 4'hf;
      r.s2         <= 4'hf;
      r.start_prev <= 1'b1;
      r.load_dac_n <= 1'b1;
      r.scan_end_n <= 1'b1;
      r.awrdy      <= 1'b1;
      r.wrdy       <= 1'b1;
      r.arrdy      <= 1'b1;
    end
    else
      r <= n;
  end

  // Ports straight from the state register
  assign AWREADY    = r.awrdy;
  assign WREADY     = r.wrdy;
  assign BVALID     = r.bvalid;
  assign BRESP      = r.bresp;
  assign ARREADY    = r.arrdy;
  assign RVALID     = r.rvalid;
  assign RDATA      = r.rdata;
  assign RRESP      = r.rresp;
  assign LOAD_DAC_N = r.load_dac_n;
  assign SCAN_END_N = r.scan_end_n;
  assign RUNNING    = r.running;
  assign TICK       = r.tick;
  assign TICK_IRQ   = r.tick_irq;
  assign REF_EN     = r.ref_en;
  assign MEM_ADDR   = r.addr;
  assign MEM_RD     = r.mem_rd;
  assign DAC_WE     = r.dac_we;
  assign DAC_SEL    = r.dac_sel;
  assign DAC_DATA   = r.dac_data;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  sequence fetch_seq;
    MEM_RD ##1 (r.st == pacer_pkg::S_WRITE);
  endsequence

  a_ldac_short: assert property ($fell(LOAD_DAC_N) |=> LOAD_DAC_N)
    else $error("conversion pulse longer than one cycle");
  a_scan_marker: assert property ((r.st == pacer_pkg::S_WRITE && MEM_RDATA[13])
    |=> !SCAN_END_N && DAC_WE)
    else $error("scan-end pulse missing");
  // A stop or a control write in the fetch cycle may end the run legally
  a_running_fetch: assert property ((r.st == pacer_pkg::S_READ && !halt_any)
    |-> RUNNING ##1 RUNNING)
    else $error("running low during fetch");
  // A restart may follow the stop at once, so running is judged at the first edge
  a_stop_rewind: assert property (stop_l |=> (r.st == pacer_pkg::S_IDLE && MEM_ADDR == 16'h0
    && !RUNNING))
    else $error("stop did not halt and rewind");
  a_trig_convert: assert property ((trig_fall && !r.mask[7]) |=> !LOAD_DAC_N)
    else $error("external trigger not passed on");
  a_hw_start: assert property ((r.st == pacer_pkg::S_IDLE && start_rise && r.ctrl[2]
    && !pause && !stop_l && r.s2[1]) |=> (r.st == pacer_pkg::S_WAIT) ##1 RUNNING)
    else $error("start edge ignored");
  a_pause_hold: assert property ((r.st == pacer_pkg::S_WAIT && pause && !halt_any)
    |=> r.st == pacer_pkg::S_WAIT)
    else $error("sequencer moved while paused");
  a_scan_done: assert property ((r.st == pacer_pkg::S_READ && !halt_any) ##1 !halt_any
    |-> fetch_seq)
    else $error("fetch cut short");
  a_tick_resume: assert property ((r.st == pacer_pkg::S_WAIT && !pause && pacer_tick && !halt_any)
    |=> !LOAD_DAC_N && r.st == pacer_pkg::S_READ)
    else $error("tick did not convert and fetch");
  a_ref_off: assert property ((!r.ctrl[6] && !do_wr) |=> !REF_EN)
    else $error("reference on while disabled");
  a_tick_irq: assert property ($rose(r.c0.out) |=> TICK && TICK_IRQ ##1 !TICK_IRQ)
    else $error("counter zero not routed");

endmodule : waveform_pacer

// *** bench/sram_model.sv ***
/*
  SRAM model on the far side of the sequencer read port.
  Assumes one-cycle MEM_RD pulses sampled on the rising edge of the clock.
*/
`timescale 1ns/10ps
module sram_model (
  input  wire logic        clock,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  output logic      [15:0] mem_rdata
);
  // Scan end on word 1 and on words 3 and beyond, stop on word 3 and beyond
  function automatic logic [15:0] word(input logic [15:0] a);
    case (a)
      16'h0000: word = 16'h0123;
      16'h0001: word = 16'h2456;
      16'h0002: word = 16'h0789;
      default:  word = 16'ha0bc;
    endcase
  endfunction : word
  // Valid only in the cycle after a read; it toggles otherwise, so a late grab is seen
  initial mem_rdata = 16'h5a5a;
  always @(posedge clock)
    mem_rdata <= mem_rd ? word(mem_addr) : ~mem_rdata;
endmodule : sram_model

// *** bench/waveform_pacer_and_run_control_tb.sv ***
/*
  Self-checking bench of the waveform pacer: AXI4-Lite master, pin drivers,
  one task per scenario. Assumes sram_model answers the cycle after a read.
*/
`timescale 1ns/10ps
`include "pacer_cfg.svh"
module waveform_pacer_and_run_control_tb;
  localparam logic [7:0] A_CTRL = `CTRL_IDX << 2;
  // Inputs start idle: pins high, no bus request
  logic        CLOCK = 1'h0, SRST = 1'h1, STOP_N = 1'h1, START_N = 1'h1, PAUSE_N = 1'h1;
  logic        TRIG_N = 1'h1, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0;
  logic        RREADY = 1'h0, AWREADY, WREADY, BVALID, ARREADY, RVALID, LOAD_DAC_N, ld_prev;
  logic        SCAN_END_N, RUNNING, TICK, TICK_IRQ, REF_EN, MEM_RD, DAC_WE, arm, aw, w, b;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0]  WSTRB = 4'hf;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [15:0] MEM_ADDR, MEM_RDATA, first_addr;
  logic [2:0]  DAC_SEL;
  logic [11:0] DAC_DATA;
  logic [14:0] last_word;
  int          fail_count = 0, checks_done = 0, we_c = 0, se_c = 0, ld_c = 0, per, hi;

  waveform_pacer i_dut (.*);
  sram_model i_sram (.clock(CLOCK), .mem_addr(MEM_ADDR), .mem_rd(MEM_RD), .mem_rdata(MEM_RDATA));
  always #50 CLOCK = ~CLOCK;

  // Pulse counters at the falling edge, where registered outputs have settled
  always @(negedge CLOCK)
  begin
    we_c += (DAC_WE === 1'h1);
    se_c += (SCAN_END_N === 1'h0);
    ld_c += (LOAD_DAC_N === 1'h0);
    if (DAC_WE === 1'h1) last_word = {DAC_SEL, DAC_DATA};
    if (LOAD_DAC_N === 1'h0 && ld_prev === 1'h0) chk(32'h1, 32'h0, "long pulse");
    ld_prev = LOAD_DAC_N;
    if (arm === 1'h1 && MEM_RD === 1'h1) {arm, first_addr} = {1'h0, MEM_ADDR};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t ns %s: got %0h want %0h", $time, msg, got, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, released after the next rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    {AWADDR, WDATA} <= {a, d};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do
    begin
      @(negedge CLOCK);
      {aw, w, b} = {AWVALID & AWREADY, WVALID & WREADY, BREADY & BVALID};
      if (b) rsp = BRESP;
      @(posedge CLOCK);
      {AWVALID, WVALID, BREADY} <= {AWVALID & !aw, WVALID & !w, BREADY & !b};
    end while (AWVALID | WVALID | BREADY);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge CLOCK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    do
    begin
      @(negedge CLOCK);
      {aw, b} = {ARVALID & ARREADY, RREADY & RVALID};
      if (b) {rd, rsp} = {RDATA, RRESP};
      @(posedge CLOCK);
      {ARVALID, RREADY} <= {ARVALID & !aw, RREADY & !b};
    end while (ARVALID | RREADY);
  endtask : axr

  task automatic wrun(input logic v, input int n);
    for (int i = 0; i < n && RUNNING !== v; i++) @(negedge CLOCK);
    // Let the pulse counters of this falling edge finish first
    #1 chk(RUNNING, v, "running level");
  endtask : wrun

  task automatic stop_pulse;
    @(posedge CLOCK) STOP_N <= 1'h0;
    repeat (4) @(posedge CLOCK);
    STOP_N <= 1'h1;
    repeat (4) @(posedge CLOCK);
  endtask : stop_pulse

  // Period and high time of the tick output over one interrupt interval
  task automatic tper(input logic [2:0] m, input logic [15:0] n);
    axw(`CTR0_IDX << 2, {13'h0, m, n});
    repeat (2) do @(negedge CLOCK); while (TICK_IRQ !== 1'h1);
    {per, hi} = 0;
    do
    begin
      @(negedge CLOCK);
      per++;
      hi += (TICK === 1'h1);
    end while (TICK_IRQ !== 1'h1);
  endtask : tper

  task automatic t_regs;
    axr(A_CTRL);
    chk(rd, `CTRL_RST, "control reset");
    axr(`AUX_IDX << 2);
    chk(rd, `AUX_RST, "aux reset");
    axr(8'hfc);
    chk(rsp, `RESP_SLVERR, "unmapped");
    axw(A_CTRL, 32'h40);
    @(negedge CLOCK) chk(REF_EN, 32'h1, "ref on");
    axw(A_CTRL, 32'h0);
    @(negedge CLOCK) chk(REF_EN, 32'h0, "ref off");
    $display("regs done");
  endtask : t_regs

  task automatic t_timers;
    for (int m = 0; m < 6; m++)
    begin
      axw(`CTR0_IDX << 2, {13'h0, m[2:0], 16'h000a});
      axr(`CTR0_IDX << 2);
      chk(rd[18:16], m[2:0], "mode");
    end
    tper(3'h2, 16'h0005);
    chk(per, 32'h5, "rate period");
    chk(hi, 32'h4, "rate high");
    tper(3'h3, 16'h0007);
    chk(per, 32'h7, "square period");
    chk(hi, 32'h4, "square high");
    $display("timers done");
  endtask : t_timers

  // Single-shot modes: interrupt pulses before and after a gate rising edge
  task automatic t_modes;
    for (int m = 0; m < 6; m++)
    begin
      if (m == 2) m = 4;
      axw(`CTR0_IDX << 2, {13'h0, m[2:0], 16'h0005});
      for (int k = 0; k < 2; k++)
      begin
        if (k) axw(`AUX_IDX << 2, 32'h0);
        if (k) axw(`AUX_IDX << 2, 32'h1);
        per = 0;
        repeat (20) @(negedge CLOCK) per += (TICK_IRQ === 1'h1);
        chk(per, (m == 4) ^ k, "single shot");
      end
    end
    $display("modes done");
  endtask : t_modes

  task automatic t_run;
    axw(`CTR1_IDX << 2, {13'h0, 3'h2, 16'h0004});
    axw(`CTR2_IDX << 2, {13'h0, 3'h2, 16'h0002});
    {we_c, se_c, ld_c, arm} = 0;
    arm = 1'h1;
    axw(A_CTRL, 32'h41);
    wrun(1'h1, 5);
    wrun(1'h0, 100);
    chk(we_c, 32'h4, "words");
    chk(se_c, 32'h2, "scan ends");
    chk(ld_c, 32'h2, "conversions");
    chk(first_addr, 32'h0, "first word");
    chk(last_word, {3'h1, 12'h0bc}, "dac data");
    $display("run done");
  endtask : t_run

  task automatic t_gate_stop;
    stop_pulse;
    we_c = 0;
    axw(A_CTRL, 32'h43);
    repeat (40) @(negedge CLOCK);
    chk(we_c, 32'h0, "gated pacer");
    axw(A_CTRL, 32'h41);
    wrun(1'h0, 100);
    chk(we_c, 32'h4, "ungated");
    stop_pulse;
    axw(`CTR1_IDX << 2, {13'h0, 3'h2, 16'h000a});
    we_c = 0;
    axw(A_CTRL, 32'h41);
    while (we_c < 2) @(negedge CLOCK);
    @(posedge CLOCK) STOP_N <= 1'h0;
    wrun(1'h0, 8);
    axw(A_CTRL, 32'h41);
    wrun(1'h0, 1);
    axw(A_CTRL, 32'h0);
    @(posedge CLOCK) STOP_N <= 1'h1;
    arm = 1'h1;
    axw(A_CTRL, 32'h41);
    wrun(1'h0, 200);
    chk(first_addr, 32'h0, "restart");
    $display("gate and stop done");
  endtask : t_gate_stop

  task automatic t_pins;
    stop_pulse;
    axw(A_CTRL, 32'h44);
    @(posedge CLOCK) START_N <= 1'h0;
    repeat (4) @(posedge CLOCK);
    START_N <= 1'h1;
    wrun(1'h1, 6);
    @(posedge CLOCK) START_N <= 1'h0;
    wrun(1'h0, 6);
    axw(A_CTRL, 32'h0);
    @(posedge CLOCK) START_N <= 1'h1;
    @(posedge CLOCK) PAUSE_N <= 1'h0;
    axw(A_CTRL, 32'h41);
    repeat (30) @(negedge CLOCK);
    wrun(1'h0, 1);
    @(posedge CLOCK) PAUSE_N <= 1'h1;
    wrun(1'h1, 6);
    wrun(1'h0, 200);
    ld_c = 0;
    for (int i = 0; i < 2; i++)
    begin
      axw(`MASK_IDX << 2, i ? 32'h80 : 32'h0);
      @(posedge CLOCK) TRIG_N <= 1'h0;
      repeat (3) @(posedge CLOCK);
      TRIG_N <= 1'h1;
      repeat (6) @(negedge CLOCK);
      chk(ld_c, 32'h1, "trigger");
    end
    $display("pins done");
  endtask : t_pins

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge CLOCK);
    SRST <= 1'h0;
    t_regs;
    t_timers;
    t_modes;
    t_run;
    t_gate_stop;
    t_pins;
    conclude;
  end

  // Watchdog well beyond the several hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    conclude;
  end
endmodule : waveform_pacer_and_run_control_tb
